// >>> ida_pkg.sv
`default_nettype none
package ida_pkg;
    // Pointer geometry: 12-bit data address, high byte carries four bits
    localparam int unsigned PTR_W      = 12;
    localparam int unsigned NUM_PTRS   = 3;
    localparam int unsigned BUS_ADDR_W = 8;

    // Register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] OFS_PTR0_LOW  = 8'h00;
    localparam logic [7:0] OFS_PTR0_HIGH = 8'h04;
    localparam logic [7:0] PTR_STRIDE    = 8'h08;
    localparam logic [7:0] OFS_WORK_ACC  = 8'h18;
    localparam logic [7:0] OFS_BANK_SEL  = 8'h1c;
    localparam logic [7:0] OFS_COND_FLGS = 8'h20;
    localparam logic [7:0] OFS_STACK_FLG = 8'h24;
    localparam logic [7:0] OFS_VIRT_BASE = 8'h40;
    localparam logic [7:0] OFS_VIRT_END  = 8'h9f;
    localparam logic [2:0] VIRT_SEL_BASE = 3'h2;

    // Implemented-bit masks and field positions
    localparam logic [7:0] HIGH_MASK   = 8'h0f;
    localparam logic [7:0] BANK_MASK   = 8'h0f;
    localparam logic [7:0] COND_MASK   = 8'h1f;
    localparam int unsigned STK_OVF_BIT = 7;
    localparam int unsigned STK_UNF_BIT = 6;

    // Values after reset
    localparam logic [PTR_W-1:0] PTR_RESET  = 12'h000;
    localparam logic [7:0]       BANK_RESET = 8'h00;
    localparam logic [7:0]       BYTE_RESET = 8'h00;
    localparam logic [1:0]       RESP_OKAY  = 2'b00;

    // Virtual access locations within one pointer's window
    typedef enum logic [2:0] {
        LOC_PLAIN   = 3'b000,
        LOC_POSTINC = 3'b001,
        LOC_POSTDEC = 3'b010,
        LOC_PREINC  = 3'b011,
        LOC_INDEXED = 3'b100
    } ida_loc_t;

    // Decoded view of a bus address
    typedef struct packed {
        logic     virt;
        logic [1:0] sel;
        ida_loc_t loc;
    } ida_dec_t;

    // Captured write request
    typedef struct packed {
        logic [BUS_ADDR_W-1:0] addr;
        logic [31:0]           data;
        logic [3:0]            strb;
    } ida_wreq_t;
endpackage
`default_nettype wire

// >>> ida_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
// Functional notes
// - Plain location: address at pointer, pointer kept
// - Post-increment: address at pointer, then add one
// - Post-decrement: address at pointer, then subtract one
// - Pre-increment: add one, then address new pointer
// - Indexed: address pointer plus sign-extended working accumulator
// - High byte: four low bits only
// - Low byte holds eight low address bits
// - Unimplemented bits and locations read zero
// - Stack flags clear only by software, reset
module ida_top
    import ida_pkg::*;
#(
    parameter int unsigned MEM_DEPTH = 256
) (
    input  wire logic                  ref_clk_i,       // Core clock
    input  wire logic                  reset_n_i,       // Async reset, active low
    input  wire logic [BUS_ADDR_W-1:0] s_awaddr_i,      // Write address
    input  wire logic                  s_awvalid_i,     // Write address valid
    output logic                       s_awready_o,     // Write address ready
    input  wire logic [31:0]           s_wdata_i,       // Write data
    input  wire logic [3:0]            s_wstrb_i,       // Write byte strobes
    input  wire logic                  s_wvalid_i,      // Write data valid
    output logic                       s_wready_o,      // Write data ready
    output logic [1:0]                 s_bresp_o,       // Write response
    output logic                       s_bvalid_o,      // Write response valid
    input  wire logic                  s_bready_i,      // Write response ready
    input  wire logic [BUS_ADDR_W-1:0] s_araddr_i,      // Read address
    input  wire logic                  s_arvalid_i,     // Read address valid
    output logic                       s_arready_o,     // Read address ready
    output logic [31:0]                s_rdata_o,       // Read data
    output logic [1:0]                 s_rresp_o,       // Read response
    output logic                       s_rvalid_o,      // Read data valid
    input  wire logic                  s_rready_i,      // Read data ready
    input  wire logic                  stack_overflow_i,  // Core pulse: stack overflowed
    input  wire logic                  stack_underflow_i, // Core pulse: stack underflowed
    output logic [7:0]                 bank_select_o    // Bank selector, to core
);

    localparam int unsigned IDX_W = $clog2(MEM_DEPTH);

    // Data memory is addressed by the low pointer bits only, so the depth must be a power of two
    localparam bit DEPTH_OK = (MEM_DEPTH >= 2) && (MEM_DEPTH <= (1 << PTR_W))
                              && ((MEM_DEPTH & (MEM_DEPTH - 1)) == 0);
    if (!DEPTH_OK) begin
        $error("MEM_DEPTH must be a power of two between 2 and 4096");
    end

    logic [PTR_W-1:0] ptr [NUM_PTRS];
    logic [7:0]       mem [MEM_DEPTH];
    logic [7:0]       work_acc;
    logic [7:0]       cond_flags;
    logic             stk_ovf;
    logic             stk_unf;
    ida_wreq_t        wreq;
    logic             aw_full;
    logic             w_full;
    logic [BUS_ADDR_W-1:0] ar_addr;
    logic             ar_full;

    // Split the bus address into pointer window and location
    function automatic ida_dec_t decode(input logic [BUS_ADDR_W-1:0] a);
        ida_dec_t d;
        d.sel  = 2'(a[7:5] - VIRT_SEL_BASE);
        d.loc  = ida_loc_t'(a[4:2]);
        d.virt = (a >= OFS_VIRT_BASE) && (a <= OFS_VIRT_END) && (a[4:2] <= 3'(LOC_INDEXED))
                 && (a[1:0] == 2'b00);
        return d;
    endfunction

    // Address that the access reaches
    function automatic logic [PTR_W-1:0] eff_addr(input logic [PTR_W-1:0] p,
                                                  input ida_loc_t loc,
                                                  input logic [7:0] w);
        unique case (loc)
            LOC_PREINC:  return PTR_W'(p + 1'b1);
            LOC_INDEXED: return PTR_W'(p + {{(PTR_W-8){w[7]}}, w});
            default:     return p;
        endcase
    endfunction

    // Pointer value after the access
    function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p,
                                                  input ida_loc_t loc);
        unique case (loc)
            LOC_POSTINC: return PTR_W'(p + 1'b1);
            LOC_POSTDEC: return PTR_W'(p - 1'b1);
            LOC_PREINC:  return PTR_W'(p + 1'b1);
            default:     return p;
        endcase
    endfunction

    // One access per cycle; a write takes precedence so pointer updates never race
    logic             do_wr;
    logic             do_rd;
    ida_dec_t         op_dec;
    logic             op_virt;
    logic [PTR_W-1:0] op_ptr;
    logic [PTR_W-1:0] op_eff;
    logic [IDX_W-1:0] op_idx;
    logic             wr_byte;

    assign do_wr   = aw_full & w_full & ~s_bvalid_o;
    assign do_rd   = ar_full & ~s_rvalid_o & ~do_wr;
    assign op_dec  = do_wr ? decode(wreq.addr) : decode(ar_addr);
    assign op_virt = (do_wr | do_rd) & op_dec.virt;
    assign op_ptr  = ptr[op_dec.sel];
    assign op_eff  = eff_addr(op_ptr, op_dec.loc, work_acc);
    assign op_idx  = op_eff[IDX_W-1:0];
    assign wr_byte = do_wr & wreq.strb[0];

    // Write address and data channels are captured independently
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_full     <= 1'b0;
            w_full      <= 1'b0;
            wreq        <= '0;
            s_awready_o <= 1'b1;
            s_wready_o  <= 1'b1;
        end else begin
            if (s_awvalid_i && s_awready_o) begin
                wreq.addr   <= s_awaddr_i;
                aw_full     <= 1'b1;
                s_awready_o <= 1'b0;
            end else if (do_wr) begin
                aw_full     <= 1'b0;
                s_awready_o <= 1'b1;
            end
            if (s_wvalid_i && s_wready_o) begin
                wreq.data  <= s_wdata_i;
                wreq.strb  <= s_wstrb_i;
                w_full     <= 1'b1;
                s_wready_o <= 1'b0;
            end else if (do_wr) begin
                w_full     <= 1'b0;
                s_wready_o <= 1'b1;
            end
        end
    end

    // Write response; unmapped addresses are accepted and ignored
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_bvalid_o <= 1'b0;
            s_bresp_o  <= RESP_OKAY;
        end else if (do_wr) begin
            s_bvalid_o <= 1'b1;
            s_bresp_o  <= RESP_OKAY;
        end else if (s_bready_i) begin
            s_bvalid_o <= 1'b0;
        end
    end

    // Read address capture; held until the access executes
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ar_full     <= 1'b0;
            ar_addr     <= '0;
            s_arready_o <= 1'b1;
        end else if (s_arvalid_i && s_arready_o) begin
            ar_addr     <= s_araddr_i;
            ar_full     <= 1'b1;
            s_arready_o <= 1'b0;
        end else if (do_rd) begin
            ar_full     <= 1'b0;
            s_arready_o <= 1'b1;
        end
    end

    // Register read view; anything not listed reads zero
    logic [7:0] reg_rd;
    always_comb begin
        reg_rd = BYTE_RESET;
        for (int i = 0; i < NUM_PTRS; i++) begin
            if (ar_addr == 8'(OFS_PTR0_LOW + PTR_STRIDE * i))
                reg_rd = ptr[i][7:0];
            if (ar_addr == 8'(OFS_PTR0_HIGH + PTR_STRIDE * i))
                reg_rd = {4'h0, ptr[i][PTR_W-1:8]};
        end
        unique case (ar_addr)
            OFS_WORK_ACC:  reg_rd = work_acc;
            OFS_BANK_SEL:  reg_rd = bank_select_o & BANK_MASK;
            OFS_COND_FLGS: reg_rd = cond_flags & COND_MASK;
            OFS_STACK_FLG: reg_rd = {stk_ovf, stk_unf, 6'h00};
            default:       reg_rd = reg_rd;
        endcase
    end

    // Read data; virtual locations return memory, upper lanes always zero
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_rvalid_o <= 1'b0;
            s_rdata_o  <= '0;
            s_rresp_o  <= RESP_OKAY;
        end else if (do_rd) begin
            s_rvalid_o <= 1'b1;
            s_rresp_o  <= RESP_OKAY;
            s_rdata_o  <= {24'h000000, op_virt ? mem[op_idx] : reg_rd};
        end else if (s_rready_i) begin
            s_rvalid_o <= 1'b0;
        end
    end

    // Pointers: virtual access update wins, only the selected set moves
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_PTRS; i++) ptr[i] <= PTR_RESET;
        end else begin
            for (int i = 0; i < NUM_PTRS; i++) begin
                if (op_virt && op_dec.sel == 2'(i)) begin
                    ptr[i] <= next_ptr(op_ptr, op_dec.loc);
                end else if (wr_byte && wreq.addr == 8'(OFS_PTR0_LOW + PTR_STRIDE * i)) begin
                    ptr[i][7:0] <= wreq.data[7:0];
                end else if (wr_byte && wreq.addr == 8'(OFS_PTR0_HIGH + PTR_STRIDE * i)) begin
                    ptr[i][PTR_W-1:8] <= wreq.data[3:0];
                end
            end
        end
    end

    // Data memory; no reset, contents are whatever software stored
    always_ff @(posedge ref_clk_i) begin
        if (op_virt && wr_byte) begin
            mem[op_idx] <= wreq.data[7:0];
        end
    end

    // Working accumulator, bank selector and condition flags
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            work_acc      <= BYTE_RESET;
            bank_select_o <= BANK_RESET;
            cond_flags    <= BYTE_RESET;
        end else if (wr_byte) begin
            if (wreq.addr == OFS_WORK_ACC) work_acc <= wreq.data[7:0];
            if (wreq.addr == OFS_BANK_SEL) bank_select_o <= wreq.data[7:0] & BANK_MASK;
            if (wreq.addr == OFS_COND_FLGS) cond_flags <= wreq.data[7:0] & COND_MASK;
        end
    end

    // Stack flags: write one to clear; a same-cycle set wins over the clear
    logic clr_ovf;
    logic clr_unf;
    assign clr_ovf = wr_byte && wreq.addr == OFS_STACK_FLG && wreq.data[STK_OVF_BIT];
    assign clr_unf = wr_byte && wreq.addr == OFS_STACK_FLG && wreq.data[STK_UNF_BIT];

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stk_ovf <= 1'b0;
            stk_unf <= 1'b0;
        end else begin
            stk_ovf <= stack_overflow_i | (stk_ovf & ~clr_ovf);
            stk_unf <= stack_underflow_i | (stk_unf & ~clr_unf);
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    logic rd_plain;
    logic rd_any_virt;
    assign rd_plain    = do_rd & op_virt & (op_dec.loc == LOC_PLAIN);
    assign rd_any_virt = do_rd & op_virt;

    property p_plain_keeps;
        rd_plain |=> ptr[$past(op_dec.sel)] == $past(op_ptr);
    endproperty
    a_plain_keeps: assert property (p_plain_keeps) else $error("plain access moved pointer");

    property p_postinc;
        op_virt && op_dec.loc == LOC_POSTINC
            |-> op_eff == op_ptr ##1 ptr[$past(op_dec.sel)] == PTR_W'($past(op_ptr) + 1'b1);
    endproperty
    a_postinc: assert property (p_postinc) else $error("post-increment wrong");

    property p_postdec;
        op_virt && op_dec.loc == LOC_POSTDEC
            |-> op_eff == op_ptr ##1 ptr[$past(op_dec.sel)] == PTR_W'($past(op_ptr) - 1'b1);
    endproperty
    a_postdec: assert property (p_postdec) else $error("post-decrement wrong");

    property p_preinc;
        op_virt && op_dec.loc == LOC_PREINC |-> op_eff == PTR_W'(op_ptr + 1'b1)
            ##1 ptr[$past(op_dec.sel)] == $past(op_eff);
    endproperty
    a_preinc: assert property (p_preinc) else $error("pre-increment wrong");

    property p_indexed;
        rd_any_virt && op_dec.loc == LOC_INDEXED
            |=> s_rvalid_o && s_rdata_o[7:0] ==
                $past(mem[IDX_W'(op_ptr + {{(PTR_W-8){work_acc[7]}}, work_acc})]);
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed read wrong");

    property p_high_narrow;
        do_rd && ar_addr == OFS_PTR0_HIGH |=> s_rdata_o[7:4] == 4'h0;
    endproperty
    a_high_narrow: assert property (p_high_narrow) else $error("high byte upper bits set");

    property p_low_write;
        wr_byte && wreq.addr == OFS_PTR0_LOW && !op_virt |=> ptr[0][7:0] == $past(wreq.data[7:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low byte not stored");

    property p_unmapped_zero;
        do_rd && !op_dec.virt && ar_addr > OFS_STACK_FLG |=> s_rdata_o == 32'h00000000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_ovf_sticky;
        stk_ovf && !clr_ovf |=> stk_ovf;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

    property p_unf_sticky;
        stk_unf && !clr_unf |=> stk_unf;
    endproperty
    a_unf_sticky: assert property (p_unf_sticky) else $error("underflow flag lost");

    property p_isolated;
        op_virt && op_dec.sel == 2'd1 |=> ptr[0] == $past(ptr[0]) && ptr[2] == $past(ptr[2]);
    endproperty
    a_isolated: assert property (p_isolated) else $error("other pointer modified");

    c_postinc_read: cover property (rd_any_virt && op_dec.loc == LOC_POSTINC);
    c_indexed_write: cover property (do_wr && op_virt && op_dec.loc == LOC_INDEXED);
    c_rd_wr_same: cover property (ar_full && do_wr);
    c_flag_clear: cover property (stk_ovf && clr_ovf ##1 !stk_ovf);

endmodule
`default_nettype wire

// >>> ida_core_model.sv
`default_nettype none
// Stand-in for the core's stack logic: it raises the overflow and underflow events
module ida_core_model (
    input  wire logic ref_clk_i,         // Core clock
    output var  logic stack_overflow_o,  // Stack overflow event
    output var  logic stack_underflow_o  // Stack underflow event
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet until the bench asks for an event
    initial begin
        stack_overflow_o  = 1'b0;
        stack_underflow_o = 1'b0;
    end

    // One-cycle event; the block must keep the flag sticky on its own
    task automatic pulse(input logic ovf, input logic unf);
        @(posedge ref_clk_i);
        stack_overflow_o  <= ovf;
        stack_underflow_o <= unf;
        @(posedge ref_clk_i);
        stack_overflow_o  <= 1'b0;
        stack_underflow_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> indirect_data_addressing_tb.sv
`default_nettype none
module indirect_data_addressing_tb;
    import ida_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [7:0]  a;
        logic [7:0]  d;
        logic [31:0] e;
    } ida_row_t;

    // Pointer windows, one per pointer set
    localparam logic [7:0] V0 = OFS_VIRT_BASE;
    localparam logic [7:0] V1 = OFS_VIRT_BASE + 8'h20;
    localparam logic [7:0] V2 = OFS_VIRT_BASE + 8'h40;

    logic        ref_clk_i, reset_n_i;
    logic [7:0]  s_awaddr_i, s_araddr_i, bank_select_o;
    logic [31:0] s_wdata_i, s_rdata_o;
    logic [3:0]  s_wstrb_i;
    logic        s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
    logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
    logic [1:0]  s_bresp_o, s_rresp_o;
    logic        stk_ovf, stk_unf;
    int          n_mismatch = 0;
    int          compares = 0;

    // Write then read back: written byte beside the value software must see
    ida_row_t rows [9] = '{
        '{OFS_PTR0_LOW, 8'hff, 32'h0000_00ff},
        '{OFS_PTR0_HIGH, 8'hff, 32'h0000_000f},
        '{OFS_PTR0_HIGH + PTR_STRIDE, 8'hf5, 32'h0000_0005},
        '{OFS_WORK_ACC, 8'h5a, 32'h0000_005a},
        '{OFS_BANK_SEL, 8'hff, 32'h0000_000f},
        '{OFS_COND_FLGS, 8'hff, 32'h0000_001f},
        '{8'h28, 8'hff, 32'h0000_0000},
        '{V0 + 8'h14, 8'hff, 32'h0000_0000},
        '{8'hfc, 8'hff, 32'h0000_0000}
    };

    ida_top #(.MEM_DEPTH(4096)) ida_top_inst (
        .ref_clk_i        (ref_clk_i),
        .reset_n_i        (reset_n_i),
        .s_awaddr_i       (s_awaddr_i),
        .s_awvalid_i      (s_awvalid_i),
        .s_awready_o      (s_awready_o),
        .s_wdata_i        (s_wdata_i),
        .s_wstrb_i        (s_wstrb_i),
        .s_wvalid_i       (s_wvalid_i),
        .s_wready_o       (s_wready_o),
        .s_bresp_o        (s_bresp_o),
        .s_bvalid_o       (s_bvalid_o),
        .s_bready_i       (s_bready_i),
        .s_araddr_i       (s_araddr_i),
        .s_arvalid_i      (s_arvalid_i),
        .s_arready_o      (s_arready_o),
        .s_rdata_o        (s_rdata_o),
        .s_rresp_o        (s_rresp_o),
        .s_rvalid_o       (s_rvalid_o),
        .s_rready_i       (s_rready_i),
        .stack_overflow_i (stk_ovf),
        .stack_underflow_i(stk_unf),
        .bank_select_o    (bank_select_o)
    );

    ida_core_model ida_core_model_inst (
        .ref_clk_i        (ref_clk_i),
        .stack_overflow_o (stk_ovf),
        .stack_underflow_o(stk_unf)
    );

    // 10 MHz core clock
    always #50 ref_clk_i = ~ref_clk_i;

    task automatic close_out();
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus write; an edge passes first so no strobe is assigned twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        s_awaddr_i  <= a;
        s_wdata_i   <= {24'h0, d};
        s_awvalid_i <= 1'b1;
        s_wvalid_i  <= 1'b1;
        s_bready_i  <= 1'b1;
        forever begin
            @(posedge ref_clk_i);
            if (s_awready_o && s_awvalid_i) s_awvalid_i <= 1'b0;
            if (s_wready_o && s_wvalid_i) s_wvalid_i <= 1'b0;
            if (s_bvalid_o) begin
                chk({30'h0, s_bresp_o}, {30'h0, RESP_OKAY});
                s_bready_i <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        s_araddr_i  <= a;
        s_arvalid_i <= 1'b1;
        s_rready_i  <= 1'b1;
        forever begin
            @(posedge ref_clk_i);
            if (s_arready_o && s_arvalid_i) s_arvalid_i <= 1'b0;
            if (s_rvalid_o) begin
                d = s_rdata_o;
                chk({30'h0, s_rresp_o}, {30'h0, RESP_OKAY});
                s_rready_i <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(v, e);
    endtask

    // A pointer is written and read back as its two bytes
    task automatic setp(input int n, input logic [11:0] v);
        wr(8'(OFS_PTR0_LOW + PTR_STRIDE * n), v[7:0]);
        wr(8'(OFS_PTR0_HIGH + PTR_STRIDE * n), {4'h0, v[11:8]});
    endtask

    task automatic chkp(input int n, input logic [11:0] e);
        logic [31:0] lo;
        logic [31:0] hi;
        rd(8'(OFS_PTR0_LOW + PTR_STRIDE * n), lo);
        rd(8'(OFS_PTR0_HIGH + PTR_STRIDE * n), hi);
        chk({20'h0, hi[3:0], lo[7:0]}, {20'h0, e});
    endtask

    task automatic do_reset();
        reset_n_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
    endtask

    // Watchdog: the whole sequence needs well under a thousand bus cycles
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        close_out();
    end

    initial begin
        logic [31:0] v;
        {ref_clk_i, reset_n_i, s_awvalid_i, s_wvalid_i, s_bready_i} = '0;
        {s_arvalid_i, s_rready_i, s_awaddr_i, s_araddr_i, s_wdata_i} = '0;
        s_wstrb_i = 4'h1;
        do_reset();
        rdc(OFS_BANK_SEL, 32'h0);
        chk({24'h0, bank_select_o}, 32'h0);
        rdc(OFS_STACK_FLG, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        chk({24'h0, bank_select_o}, 32'h0000_000f);
        // Each access kind, with a carry across the byte boundary
        setp(0, 12'h123);
        setp(1, 12'h0ff);
        setp(2, 12'h456);
        wr(V1, 8'h11);
        chkp(1, 12'h0ff);
        rdc(V1, 32'h11);
        wr(V1 + 8'h04, 8'h22);
        chkp(1, 12'h100);
        wr(V1 + 8'h08, 8'h33);
        chkp(1, 12'h0ff);
        rdc(V1, 32'h22);
        rdc(V1 + 8'h0c, 32'h33);
        chkp(1, 12'h100);
        wr(OFS_WORK_ACC, 8'hff);
        rdc(V1 + 8'h10, 32'h22);
        chkp(1, 12'h100);
        chkp(0, 12'h123);
        chkp(2, 12'h456);
        wr(V2, 8'h44);
        rdc(V2 + 8'h04, 32'h44);
        chkp(2, 12'h457);
        // A write and a read at once: the write executes first
        fork
            wr(V2 + 8'h10, 8'h66);
            rd(V2 + 8'h10, v);
        join
        chk(v, 32'h66);
        wr(V2 + 8'h0c, 8'h77);
        rdc(V2 + 8'h08, 32'h77);
        chkp(2, 12'h457);
        chkp(1, 12'h100);
        // Twelve-bit wrap at both ends
        setp(0, 12'h000);
        wr(V0 + 8'h08, 8'h55);
        chkp(0, 12'hfff);
        rdc(V0 + 8'h0c, 32'h55);
        chkp(0, 12'h000);
        // Sticky stack flags: only a clearing write or a reset removes them
        ida_core_model_inst.pulse(1'b1, 1'b0);
        repeat (20) @(posedge ref_clk_i);
        rdc(OFS_STACK_FLG, 32'h80);
        wr(OFS_STACK_FLG, 8'h40);
        rdc(OFS_STACK_FLG, 32'h80);
        ida_core_model_inst.pulse(1'b0, 1'b1);
        rdc(OFS_STACK_FLG, 32'hc0);
        wr(OFS_STACK_FLG, 8'h80);
        rdc(OFS_STACK_FLG, 32'h40);
        wr(OFS_STACK_FLG, 8'hc0);
        rdc(OFS_STACK_FLG, 32'h0);
        // Event and clearing write in one cycle: the event wins
        fork
            wr(OFS_STACK_FLG, 8'h80);
            begin
                @(posedge ref_clk_i);
                ida_core_model_inst.pulse(1'b1, 1'b0);
            end
        join
        rdc(OFS_STACK_FLG, 32'h80);
        ida_core_model_inst.pulse(1'b1, 1'b1);
        rdc(OFS_STACK_FLG, 32'hc0);
        do_reset();
        rdc(OFS_STACK_FLG, 32'h0);
        rdc(OFS_BANK_SEL, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
